/* File: rtl/sts_pkg.sv */
// constants, register layouts and carrier types of the state trigger sequencer
//
// Overview of operation
// [R1] Channels come in five pods of sixteen; each pod goes to analyzer one, two or none.
// [R2] Untagged acquisition holds 1024 stored samples per channel.
// [R3] Five clock inputs serve one or two state analyzers at once.
// [R4] Selected clock edges are ORed; single, demultiplexed and mixed clocking supported.
// [R5] Each clock input picks rising, falling or both edges independently.
// [R6] Levels on up to four clock inputs are ANDed to gate the strobe.
// [R7] A pattern recognizer matches when all assigned bits equal 0, 1 or don't care.
// [R8] Eight recognizers with one analyzer on; four each when both are on.
// [R9] One range recognizer up to 32 bits, owned by the first enabled analyzer.
// [R10] Qualifiers: always, never, one pattern, range, or pattern/range combinations.
// [R11] Eight sequence levels; trigger may sit in any of the first seven.
// [R12] Each level's branch qualifier jumps to start or to a programmed level.
// [R13] Each level needs its sequence qualifier met up to 65535 times to advance.
// [R14] Only states passing the active level's storage qualifier are stored; the code also stores the trigger state without that qualifier.
// [R15] Enable and disable terms bound a post-trigger window, still storage qualified.
// [R16] Prestore also keeps the two qualified states before each stored state.
// [R17] State tagging counts qualified states between stores, to previous or trigger.
// [R18] Time tagging measures time between stores, to previous or trigger, 48 hours.
// [R19] Tagging halves the depth; the target spaces sampled states at least 60 ns.
// [R20] The occurrence counter clears whenever a level is entered.
// [R21] Range compares the label as unsigned, both bounds inclusive.
package sts_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_PODS = 5;
  localparam int POD_W = 16;
  localparam int N_CH = 80;
  localparam int N_CLK = 5;
  localparam int N_CQ = 4;
  localparam int N_PAT = 8;
  localparam int N_LVL = 8;
  localparam int LVL_W = 3;
  localparam int OCC_W = 16;
  localparam int RNG_W = 32;
  localparam int MEM_DEPTH = 1024;
  localparam int TAG_W = 48;
  localparam int ADR_W = 10;
  localparam int PAT_WORDS = 3;
  localparam int GAP_W = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PS = 5000;
  localparam int PS_PER_NS = 1000;
  localparam int STATE_GAP_NS = 60;
  localparam logic [GAP_W-1:0] GAP_CYC =
    GAP_W'((STATE_GAP_NS * PS_PER_NS + CLK_PS - 1) / CLK_PS);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] TRIG_LVL_MAX = 3'h6;
  localparam logic [LVL_W-1:0] LAST_LVL = 3'h7;
  localparam logic [OCC_W-1:0] OCC_ONE = 16'h0001;
  localparam logic [N_PAT-1:0] PAT_ALL = 8'hFF;
  localparam logic [N_PAT-1:0] PAT_SPLIT = 8'h0F;
  localparam logic [RNG_W-1:0] RNG_ONES = 32'hFFFFFFFF;
  localparam logic [4:0] RNG_TOP = 5'h1F;

  // ----------------------------------------------------------------
  // register map and write masks
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] A_CTRL = 10'h000;
  localparam logic [ADR_W-1:0] A_STATUS = 10'h004;
  localparam logic [ADR_W-1:0] A_PODS = 10'h008;
  localparam logic [ADR_W-1:0] A_CLK = 10'h00C;
  localparam logic [ADR_W-1:0] A_CLK2 = 10'h010;
  localparam logic [ADR_W-1:0] A_RCFG = 10'h014;
  localparam logic [ADR_W-1:0] A_RLO = 10'h018;
  localparam logic [ADR_W-1:0] A_RHI = 10'h01C;
  localparam logic [ADR_W-1:0] A_WIN = 10'h020;
  localparam logic [3:0] LVL_REGION = 4'h1;
  localparam logic [1:0] PAT_REGION = 2'h1;
  localparam logic [1:0] PAT_LAST_WORD = 2'h2;
  localparam logic [31:0] M_CTRL = 32'h00001FFF;
  localparam logic [31:0] M_PODS = 32'h000003FF;
  localparam logic [31:0] M_CLK = 32'h0F0F1F1F;
  localparam logic [31:0] M_CLK2 = 32'h001F1F1F;
  localparam logic [31:0] M_RCFG = 32'h00001F7F;
  localparam logic [31:0] M_QP = 32'h07FF07FF;
  localparam logic [31:0] M_LB = 32'hFFFF77FF;
  localparam logic [31:0] M_W2 = 32'h0000FFFF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {POD_OFF, POD_A1, POD_A2} pod_t;
  typedef enum logic [1:0] {CM_SINGLE, CM_DEMUX, CM_MIXED} clk_mode_t;
  typedef enum logic [1:0] {TG_OFF, TG_STATE, TG_TIME} tag_mode_t;
  typedef enum logic [1:0] {Q_NEVER, Q_ALWAYS, Q_OR, Q_AND} qkind_t;

  typedef struct packed {
    qkind_t kind; logic rng; logic [N_PAT-1:0] pat;
  } qual_t;
  typedef struct packed {
    logic [4:0] r1; qual_t hi; logic [4:0] r0; qual_t lo;
  } qpair_t;
  typedef struct packed {
    logic [OCC_W-1:0] occ; logic r1; logic [LVL_W-1:0] target;
    logic r0; qual_t br;
  } lvl_b_t;
  typedef struct packed {
    logic [18:0] rsvd; logic [LVL_W-1:0] trig_lvl; clk_mode_t clk_mode;
    logic win_en; logic tag_rel_trig; tag_mode_t tag_mode; logic prestore;
    logic ana2_on; logic ana1_on; logic arm;
  } ctrl_t;
  typedef struct packed {
    logic [3:0] r3; logic [N_CQ-1:0] qual_lvl; logic [3:0] r2;
    logic [N_CQ-1:0] qual_en; logic [2:0] r1; logic [N_CLK-1:0] fall;
    logic [2:0] r0; logic [N_CLK-1:0] rise;
  } clk_t;
  typedef struct packed {
    logic [10:0] r2; logic [N_PODS-1:0] merge; logic [2:0] r1;
    logic [N_CLK-1:0] fall; logic [2:0] r0; logic [N_CLK-1:0] rise;
  } clk2_t;
  typedef struct packed {
    logic [18:0] r1; logic [4:0] width_m1; logic r0; logic [6:0] start;
  } rcfg_t;
  typedef struct packed {
    logic [4:0] r1; logic [10:0] stored; logic [6:0] r0; logic overrun;
    logic own_v; logic own; logic win_open; logic full; logic trig;
    logic [LVL_W-1:0] lvl;
  } status_t;
  typedef struct packed {
    logic [3:0] region; logic [LVL_W-1:0] lvl; logic ab; logic [1:0] b;
  } lvl_adr_t;
  typedef struct packed {
    logic [1:0] region; logic [2:0] k; logic half; logic [1:0] w;
    logic [1:0] b;
  } pat_adr_t;
  typedef struct packed {
    logic trig; logic pre; logic [TAG_W-1:0] tag; logic [N_CH-1:0] data;
  } sample_t;

endpackage

/* File: rtl/state_trigger_sequencer.sv */
// state-mode clocking, recognizers, trigger sequencer and store control
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module state_trigger_sequencer import sts_pkg::*; #(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // system
  input wire logic clk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // probe pods
  input wire logic [N_CH-1:0] chan,
  input wire logic [N_CLK-1:0] probe_clk,
  // acquisition memory
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output sample_t mem_wdata,
  // status
  output logic [LVL_W-1:0] level,
  output logic triggered,
  output logic done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef logic [AW:0] cnt_t;
  typedef logic [PAT_WORDS-1:0][31:0] pword_t;
  typedef pod_t [N_PODS-1:0] pod_map_t;

  typedef struct packed {
    ctrl_t ctrl;
    pod_map_t pods;
    clk_t ck;
    clk2_t ck2;
    rcfg_t rc;
    logic [RNG_W-1:0] rlo;
    logic [RNG_W-1:0] rhi;
    qpair_t win;
    qpair_t [N_LVL-1:0] la;
    lvl_b_t [N_LVL-1:0] lb;
    pword_t [N_PAT-1:0] pval;
    pword_t [N_PAT-1:0] pmask;
    logic ack;
    logic [31:0] rdat;
    logic arm_p;
    logic a1_p;
    logic a2_p;
    logic own_v;
    logic own;
    logic [N_CLK-1:0] clkp;
    logic [N_CH-1:0] slave;
    logic [LVL_W-1:0] lvl;
    logic [OCC_W-1:0] occ;
    logic trig;
    logic win_open;
    logic full;
    sample_t [1:0] pre;
    logic [1:0] pre_v;
    sample_t [2:0] pend;
    logic [2:0] pend_v;
    logic [TAG_W-1:0] tagc;
    logic [TAG_W-1:0] tag_prev;
    logic [TAG_W-1:0] tag_trig;
    logic [AW-1:0] wptr;
    cnt_t post;
    cnt_t cnt;
    logic [GAP_W-1:0] gap;
    logic overrun;
    logic mwe;
    logic [AW-1:0] maddr;
    sample_t mdat;
  } st_t;

  st_t s_q;
  st_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic qual(qual_t q, logic [N_PAT-1:0] p, logic r);
    logic [N_PAT:0] sel;
    logic [N_PAT:0] hit;
    sel = {q.rng, q.pat};
    hit = {r, p};
    case (q.kind)
      Q_ALWAYS: qual = 1'b1;
      Q_OR: qual = |(sel & hit);
      Q_AND: qual = (|sel) & (&(hit | ~sel));
      default: qual = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge_be(logic [31:0] o, logic [31:0] n,
                                           logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sampling strobe and recognizers
  // ----------------------------------------------------------------
  logic [N_CLK-1:0] rise;
  logic [N_CLK-1:0] fall;
  logic m_edge;
  logic s_edge;
  logic cq_ok;
  logic strobe;
  logic run;
  logic [N_CH-1:0] a1_ch;
  logic [N_CH-1:0] merge_ch;
  logic [N_CH-1:0] smp;
  logic [N_PAT-1:0] pat_ok;
  logic [N_PAT-1:0] pat_hit;
  logic [RNG_W-1:0] rng_msk;
  logic [RNG_W-1:0] rng_val;
  logic rng_hit;
  logic tag_on;
  cnt_t lim;
  logic [LVL_W-1:0] tl;
  status_t st;

  assign rise = probe_clk & ~s_q.clkp;
  assign fall = ~probe_clk & s_q.clkp;
  assign m_edge = |((rise & s_q.ck.rise) | (fall & s_q.ck.fall)); // [R3] [R4] [R5]
  assign s_edge = |((rise & s_q.ck2.rise) | (fall & s_q.ck2.fall)); // [R5]
  assign cq_ok = &(~s_q.ck.qual_en |
                   ~(probe_clk[N_CQ-1:0] ^ s_q.ck.qual_lvl)); // [R6]
  assign strobe = cq_ok & (m_edge |
                  (s_edge & (s_q.ctrl.clk_mode == CM_DEMUX))); // [R4]

  for (genvar p = 0; p < N_PODS; p++) begin : g_pod
    assign a1_ch[p*POD_W +: POD_W] = {POD_W{s_q.pods[p] == POD_A1}}; // [R1]
    assign merge_ch[p*POD_W +: POD_W] = {POD_W{s_q.ck2.merge[p]}};
  end

  assign smp = (s_q.ctrl.clk_mode == CM_MIXED) ?
               ((merge_ch & s_q.slave) | (~merge_ch & chan)) : chan; // [R4]
  assign pat_ok = (s_q.ctrl.ana1_on & s_q.ctrl.ana2_on) ?
                  PAT_SPLIT : PAT_ALL; // [R8]

  for (genvar k = 0; k < N_PAT; k++) begin : g_pat
    assign pat_hit[k] = pat_ok[k] &
      (&(~(s_q.pmask[k][N_CH-1:0] & a1_ch) |
         ~(smp ^ s_q.pval[k][N_CH-1:0]))); // [R7]
  end

  assign rng_msk = RNG_ONES >> (RNG_TOP - s_q.rc.width_m1); // [R9]
  assign rng_val = RNG_W'(smp >> s_q.rc.start) & rng_msk;
  assign rng_hit = s_q.own_v & ~s_q.own &
                   (rng_val >= (s_q.rlo & rng_msk)) &
                   (rng_val <= (s_q.rhi & rng_msk)); // [R9] [R21]

  assign tag_on = s_q.ctrl.tag_mode != TG_OFF;
  assign lim = tag_on ? cnt_t'(DEPTH / 2) : cnt_t'(DEPTH); // [R2] [R19]
  assign run = s_q.ctrl.arm & ~s_q.full;
  assign tl = (s_q.ctrl.trig_lvl > TRIG_LVL_MAX) ?
              TRIG_LVL_MAX : s_q.ctrl.trig_lvl; // [R11]

  assign st = '{r1: '0, stored: 11'(s_q.cnt), r0: '0,
                overrun: s_q.overrun, own_v: s_q.own_v, own: s_q.own,
                win_open: s_q.win_open, full: s_q.full, trig: s_q.trig,
                lvl: s_q.lvl};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    lvl_adr_t la_a;
    pat_adr_t pa;
    logic q_seq;
    logic q_br;
    logic q_st;
    logic q_en;
    logic q_dis;
    logic fire;
    logic store;
    sample_t cur;
    sample_t w;
    logic [OCC_W-1:0] need;
    rd = '0;
    wv = '0;
    la_a = lvl_adr_t'(wb_adr);
    pa = pat_adr_t'(wb_adr);
    q_seq = qual(s_q.la[s_q.lvl].lo, pat_hit, rng_hit); // [R10]
    q_st = qual(s_q.la[s_q.lvl].hi, pat_hit, rng_hit);
    q_br = qual(s_q.lb[s_q.lvl].br, pat_hit, rng_hit);
    q_en = qual(s_q.win.lo, pat_hit, rng_hit);
    q_dis = qual(s_q.win.hi, pat_hit, rng_hit);
    fire = 1'b0;
    store = 1'b0;
    cur = '0;
    w = '0;
    need = (s_q.lb[s_q.lvl].occ == '0) ? OCC_ONE : s_q.lb[s_q.lvl].occ;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.mwe = 1'b0;
    s_d.clkp = probe_clk;
    s_d.arm_p = s_q.ctrl.arm;
    s_d.a1_p = s_q.ctrl.ana1_on;
    s_d.a2_p = s_q.ctrl.ana2_on;

    // register access
    if (wb_cyc && wb_stb && !s_q.ack) begin
      s_d.ack = 1'b1;
      case (wb_adr)
        A_CTRL: rd = s_q.ctrl;
        A_STATUS: rd = st;
        A_PODS: rd = 32'(s_q.pods);
        A_CLK: rd = s_q.ck;
        A_CLK2: rd = s_q.ck2;
        A_RCFG: rd = s_q.rc;
        A_RLO: rd = s_q.rlo;
        A_RHI: rd = s_q.rhi;
        A_WIN: rd = s_q.win;
        default: begin
          if (la_a.region == LVL_REGION) begin
            rd = la_a.ab ? s_q.lb[la_a.lvl] : s_q.la[la_a.lvl];
          end else if (pa.region == PAT_REGION && pa.w <= PAT_LAST_WORD) begin
            rd = pa.half ? s_q.pmask[pa.k][pa.w] : s_q.pval[pa.k][pa.w];
          end
        end
      endcase
      s_d.rdat = rd;
      if (wb_we) begin
        wv = merge_be(rd, wb_dat_w, wb_sel);
        case (wb_adr)
          A_CTRL: s_d.ctrl = ctrl_t'(wv & M_CTRL);
          A_PODS: s_d.pods = pod_map_t'(wv[N_PODS*2-1:0] &
                                        M_PODS[N_PODS*2-1:0]); // [R1]
          A_CLK: s_d.ck = clk_t'(wv & M_CLK);
          A_CLK2: s_d.ck2 = clk2_t'(wv & M_CLK2);
          A_RCFG: s_d.rc = rcfg_t'(wv & M_RCFG);
          A_RLO: s_d.rlo = wv;
          A_RHI: s_d.rhi = wv;
          A_WIN: s_d.win = qpair_t'(wv & M_QP);
          default: begin
            if (la_a.region == LVL_REGION) begin
              if (la_a.ab) begin
                s_d.lb[la_a.lvl] = lvl_b_t'(wv & M_LB);
              end else begin
                s_d.la[la_a.lvl] = qpair_t'(wv & M_QP);
              end
            end else if (pa.region == PAT_REGION &&
                         pa.w <= PAT_LAST_WORD) begin
              if (pa.w == PAT_LAST_WORD) begin
                wv = wv & M_W2;
              end
              if (pa.half) begin
                s_d.pmask[pa.k][pa.w] = wv;
              end else begin
                s_d.pval[pa.k][pa.w] = wv;
              end
            end
          end
        endcase
      end
    end

    // range recognizer ownership
    if (s_q.ctrl.ana1_on && !s_q.a1_p && !s_q.own_v) begin // [R9]
      s_d.own_v = 1'b1;
      s_d.own = 1'b0;
    end else if (s_q.ctrl.ana2_on && !s_q.a2_p && !s_q.own_v) begin
      s_d.own_v = 1'b1;
      s_d.own = 1'b1;
    end else if (!s_q.ctrl.ana1_on && !s_q.ctrl.ana2_on) begin
      s_d.own_v = 1'b0;
    end

    // slave latch for mixed clocking
    if (s_edge && cq_ok) begin
      s_d.slave = chan; // [R4]
    end

    if (s_q.ctrl.arm && !s_q.arm_p) begin
      // start of a run
      s_d.lvl = '0;
      s_d.occ = '0;
      s_d.trig = 1'b0;
      s_d.win_open = 1'b0;
      s_d.full = 1'b0;
      s_d.pre_v = '0;
      s_d.pend_v = '0;
      s_d.tagc = '0;
      s_d.tag_prev = '0;
      s_d.tag_trig = '0;
      s_d.wptr = '0;
      s_d.post = '0;
      s_d.cnt = '0;
      s_d.gap = '0;
      s_d.overrun = 1'b0;
    end else if (run) begin
      if (s_q.ctrl.tag_mode == TG_TIME) begin
        s_d.tagc = s_q.tagc + 1'b1; // [R18]
      end
      if (s_q.gap != GAP_CYC) begin
        s_d.gap = s_q.gap + 1'b1;
      end

      // drain of pending stores, one per cycle
      if (s_q.pend_v[0]) begin
        w = s_q.pend[0];
        if (!tag_on) begin
          w.tag = '0;
        end else if (s_q.ctrl.tag_rel_trig) begin
          w.tag = s_q.pend[0].tag - s_q.tag_trig; // [R17] [R18]
        end else begin
          w.tag = s_q.pend[0].tag - s_q.tag_prev; // [R17] [R18]
        end
        s_d.tag_prev = s_q.pend[0].tag;
        s_d.mwe = 1'b1;
        s_d.maddr = s_q.wptr;
        s_d.mdat = w;
        if (cnt_t'(s_q.wptr) == lim - 1'b1) begin
          s_d.wptr = '0; // [R19]
        end else begin
          s_d.wptr = s_q.wptr + 1'b1; // [R2]
        end
        if (s_q.cnt != lim) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
        if (s_q.trig) begin
          s_d.post = s_q.post + 1'b1;
          if (s_q.post == (lim >> 1) - 1'b1) begin
            s_d.full = 1'b1;
          end
        end
      end
      s_d.pend[0] = s_q.pend[1];
      s_d.pend[1] = s_q.pend[2];
      s_d.pend_v = {1'b0, s_q.pend_v[2:1]};

      if (strobe) begin
        if (s_q.ctrl.tag_mode == TG_STATE) begin
          s_d.tagc = s_q.tagc + 1'b1; // [R17]
        end
        s_d.gap = '0;
        if (tag_on && s_q.gap != GAP_CYC) begin
          s_d.overrun = 1'b1; // [R19]
        end

        // trigger sequencer
        if (q_br) begin
          s_d.lvl = s_q.lb[s_q.lvl].target; // [R12]
          s_d.occ = '0; // [R20]
        end else if (q_seq) begin
          if ({1'b0, s_q.occ} + 1'b1 >= {1'b0, need}) begin // [R13]
            if (s_q.lvl == tl && !s_q.trig) begin
              fire = 1'b1; // [R11]
            end
            if (s_q.lvl != LAST_LVL) begin
              s_d.lvl = s_q.lvl + 1'b1;
              s_d.occ = '0; // [R20]
            end
          end else begin
            s_d.occ = s_q.occ + 1'b1; // [R13]
          end
        end
        if (fire) begin
          s_d.trig = 1'b1;
          s_d.tag_trig = s_q.tagc;
        end

        // post-trigger window
        if (s_q.trig && s_q.ctrl.win_en) begin
          if (s_q.win_open && q_dis) begin
            s_d.win_open = 1'b0; // [R15]
          end else if (!s_q.win_open && q_en) begin
            s_d.win_open = 1'b1; // [R15]
          end
        end

        store = fire | (q_st & (!s_q.trig || !s_q.ctrl.win_en ||
                                s_q.win_open)); // [R14] [R15]
        cur.trig = fire;
        cur.pre = 1'b0;
        cur.tag = s_q.tagc;
        cur.data = smp;
        if (store && s_q.ctrl.prestore) begin
          s_d.pend[0] = s_q.pre[0]; // [R16]
          s_d.pend[1] = s_q.pre[1];
          s_d.pend[2] = cur;
          s_d.pend_v = {1'b1, s_q.pre_v};
          s_d.pre_v = '0;
        end else if (store) begin
          s_d.pend[0] = cur;
          s_d.pend_v = 3'h1;
        end else if (s_q.ctrl.prestore) begin
          cur.pre = 1'b1;
          s_d.pre[0] = s_q.pre[1]; // [R16]
          s_d.pre[1] = cur;
          s_d.pre_v = {1'b1, s_q.pre_v[1]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack = s_q.ack;
  assign wb_dat_r = s_q.rdat;
  assign mem_we = s_q.mwe;
  assign mem_addr = s_q.maddr;
  assign mem_wdata = s_q.mdat;
  assign level = s_q.lvl;
  assign triggered = s_q.trig;
  assign done = s_q.full;

endmodule

/* File: sim/sts_target.sv */
// target system model driving the probe pods and clock inputs
`timescale 1ns/1ps
module sts_target import sts_pkg::*; (
  // system
  input wire logic clk,
  input wire logic resetn,
  // bench request
  input wire logic fire,
  input wire logic [N_CH-1:0] pat,
  // probe side
  output logic [N_CH-1:0] chan,
  output logic [N_CLK-1:0] probe_clk,
  output logic busy
);
  logic [3:0] cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
      chan <= '0;
      probe_clk <= '0;
      busy <= 1'b0;
    end else if (fire && !busy) begin
      busy <= 1'b1;
      cnt_q <= 4'h1;
      chan <= pat;
    end else if (busy) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h1)
        probe_clk[0] <= 1'b1;
      if (cnt_q == 4'h3)
        chan <= ~chan;
      if (cnt_q == 4'h6)
        probe_clk[0] <= 1'b0;
      if (cnt_q == 4'hC)
        busy <= 1'b0;
    end else begin
      chan <= ~chan;
    end
  end
endmodule

/* File: sim/sts_chk.sv */
// assertion checker of the state trigger sequencer ports
`timescale 1ns/1ps
module sts_chk import sts_pkg::*; #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic wb_ack,
  input wire logic [N_CH-1:0] chan,
  input wire logic mem_we,
  input wire logic [AW-1:0] mem_addr,
  input wire sample_t mem_wdata,
  input wire logic [LVL_W-1:0] level,
  input wire logic triggered,
  input wire logic done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [AW-1:0] last_q;
  logic seen_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_q <= '0;
      seen_q <= 1'b0;
    end else if (mem_we) begin
      last_q <= mem_addr;
      seen_q <= 1'b1;
    end
  end

  sequence req_s;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence trig_wr_s;
    mem_we && mem_wdata.trig;
  endsequence

  ack_once_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  ack_reply_a: assert property (req_s |=> wb_ack)
    else $error("no ack after request");
  ack_idle_a: assert property (!wb_stb |=> !wb_ack)
    else $error("ack without request");
  store_data_a: assert property (
    mem_we && !mem_wdata.pre |-> mem_wdata.data == $past(chan, 2))
    else $error("stored data differs from sample");
  addr_step_a: assert property (
    mem_we && seen_q |-> mem_addr == last_q + 1'b1)
    else $error("store address skipped");
  halt_store_a: assert property (done && $past(done) |-> !mem_we)
    else $error("store after run end");
  trig_level_a: assert property (
    $rose(triggered) |-> $past(level) != LAST_LVL)
    else $error("trigger from last level");
  trig_entry_a: assert property (trig_wr_s |-> ##[0:2] triggered)
    else $error("trigger entry without trigger");
  trig_hold_a: assert property (
    triggered && !(wb_stb && wb_we) |=> triggered)
    else $error("trigger flag lost");
  done_trig_a: assert property (done |-> triggered)
    else $error("run end before trigger");
endmodule

bind state_trigger_sequencer sts_chk #(.AW(AW)) u_chk (.clk(clk),
  .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_ack(wb_ack), .chan(chan), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .level(level), .triggered(triggered),
  .done(done));

/* File: sim/testbench.sv */
// self-checking bench of the state trigger sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench import sts_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat_w = '0;
  logic [31:0] wb_dat_r, rd;
  logic wb_ack, mem_we, triggered, done, busy;
  logic fire = 1'b0;
  logic [N_CH-1:0] chan, d;
  logic [N_CH-1:0] pat = '0;
  logic [N_CLK-1:0] probe_clk;
  logic [3:0] mem_addr;
  sample_t mem_wdata;
  logic [LVL_W-1:0] level;
  logic [7:0] v;
  int n_fail = 0;
  int check_count = 0;
  int we_seen = 0;
  int cyc = 0;
  int seed = 32'h49a17b0a;
  int n, k, hits;

  always #2.5 clk = ~clk;

  state_trigger_sequencer #(.DEPTH(16)) i_dut (.clk(clk), .resetn(resetn),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .chan(chan), .probe_clk(probe_clk), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .level(level),
    .triggered(triggered), .done(done));
  sts_target i_tgt (.clk(clk), .resetn(resetn), .fire(fire), .pat(pat),
    .chan(chan), .probe_clk(probe_clk), .busy(busy));

  // ----
  // helpers
  // ----
  function automatic logic [N_CH-1:0] rnd();
    return {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
  endfunction

  function automatic int hit(input logic [N_CH-1:0] x, input logic [7:0] m);
    return int'(x[7:0] == m);
  endfunction

  task automatic xfer(input logic we, input logic [ADR_W-1:0] a,
                      input logic [31:0] wd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= wd;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic probe(input logic [N_CH-1:0] x);
    fire <= 1'b1;
    pat <= x;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask

  task automatic close_out();
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (mem_we === 1'b1)
      we_seen++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    xfer(1'b0, A_CTRL, '0);
    `CHK("ctrl reset", 32'h0, rd)
    xfer(1'b0, 10'h3FC, '0);
    `CHK("unmapped", 32'h0, rd)
    d = rnd();
    xfer(1'b1, A_PODS, d[31:0]);
    xfer(1'b0, A_PODS, '0);
    `CHK("pods", d[31:0] & M_PODS, rd)
    xfer(1'b1, A_STATUS, 32'hFFFFFFFF);
    xfer(1'b0, A_STATUS, '0);
    `CHK("status", 32'h0, rd)
    xfer(1'b1, A_PODS, 32'h1);
    xfer(1'b1, A_CLK, 32'h1);
    v = 8'($random(seed));
    xfer(1'b1, 10'h100, {24'h0, v});
    xfer(1'b1, 10'h110, 32'hFF);
    xfer(1'b1, 10'h040, 32'h02000401);
    n = 2 + ($random(seed) & 3);
    xfer(1'b1, 10'h044, 32'(n) << 16);
    xfer(1'b1, 10'h048, 32'h02000000);
    xfer(1'b1, A_CTRL, 32'h3);
    hits = 0;
    k = 0;
    while (hits < n) begin
      d = rnd();
      d[7:0] = ($random(seed) & 1) ? v : v ^ 8'h01;
      probe(d);
      k++;
      hits += hit(d, v);
      `CHK("triggered", 1'(hits >= n), triggered)
    end
    `CHK("stored", k, we_seen)
    `CHK("level", 3'h1, level)
    xfer(1'b0, A_STATUS, '0);
    `CHK("status run", {5'h0, 11'(k > 16 ? 16 : k), 16'h0089}, rd)
    repeat (9) probe(rnd());
    `CHK("done", 1'b1, done)
    k = we_seen;
    probe(rnd());
    `CHK("halted", k, we_seen)
    close_out();
  end
endmodule
